// [verilog/hpil_pkg.sv]
// Purpose: shared constants and carrier structs for the host port and irq pin logic
// Assumes: single clock sys_clk at 100 MHz, active-low asynchronous reset
// Notes: register positions below are the internal map chosen for this block
package hpil_pkg;
    // uart channel register indices (3-bit select)
    localparam logic [2:0] UART_IER_IDX = 3'h1; // interrupt enable register
    localparam logic [2:0] UART_MCR_IDX = 3'h4; // modem control register
    // printer port register indices (2-bit select)
    localparam logic [1:0] PRN_DATA_IDX = 2'h0; // printer data port
    localparam logic [1:0] PRN_STAT_IDX = 2'h1; // printer status
    localparam logic [1:0] PRN_CTRL_IDX = 2'h2; // printer control
    // field positions
    localparam int MCR_IRQ_OE_BIT = 3; // modem control bit gating channel irq pin
    localparam int CON_IRQ_EN_BIT = 4; // printer control bit enabling printer irq
    localparam int CON_DIR_IN_BIT = 5; // printer control bit selecting input direction
    localparam int CON_INIT_BIT = 2; // printer control bit driving init line low
    // reset values
    localparam logic [7:0] IER_RST = 8'h00;
    localparam logic [7:0] MCR_RST = 8'h00;
    localparam logic [7:0] CON_RST = 8'h00;
    localparam logic [7:0] PDATA_RST = 8'h00;
    localparam logic [7:0] BUS_IDLE = 8'h00; // read value of unmapped locations
    // synchroniser depth
    localparam int SYNC_STAGES = 2;

    // raw interrupt conditions of one uart channel
    typedef struct packed {
        logic modem_change; // modem status change flag
        logic tx_empty; // transmit holding buffer empty
        logic rx_avail; // receive data available
        logic rx_error; // receiver line error
    } hpil_irq_src_s;

    // printer status inputs
    typedef struct packed {
        logic ack_n; // acknowledge from printer
        logic fault_n; // printer error
        logic paper_out; // paper empty
    } hpil_prn_in_s;

    // host transfer request as seen after synchronising
    typedef enum logic [2:0] {
        HPIL_IDLE = 3'b001,
        HPIL_READ = 3'b010,
        HPIL_WRITE = 3'b100
    } hpil_state_e;
endpackage : hpil_pkg

// [verilog/hpil_sync.sv]
// Purpose: two-stage synchroniser for a vector of asynchronous levels
// Assumes: reset value of every bit is given by a constant parameter
// Notes: only the second stage is visible outside
`timescale 1ns/10ps
module hpil_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r; // first stage, read only by second stage
    logic [WIDTH-1:0] meta_nxt;
    logic [WIDTH-1:0] sync_nxt;

    // next values: shift one stage when enabled
    always_comb begin
        meta_nxt = meta_r;
        sync_nxt = sync_out;
        if (clk_en) begin
            meta_nxt = async_in;
            sync_nxt = meta_r;
        end
    end

    // registers
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_r <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            meta_r <= meta_nxt;
            sync_out <= sync_nxt;
        end
    end
endmodule : hpil_sync

// [verilog/hpil_top.sv]
// Purpose: host strobes, channel irq pins, printer port and printer irq logic
// Assumes: strobes and printer inputs are asynchronous; pull-ups are external pads
// Notes: all outputs registered except init_out, tied low; a pin enable high means this block drives it
`timescale 1ns/10ps
module hpil_top #(
    parameter bit INVERTED_VARIANT = 1'b0 // latched irq releases high when set
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // host side
    input wire logic host_read_strobe_n,
    input wire logic host_write_strobe_n,
    input wire logic chan_a_select_n,
    input wire logic chan_b_select_n,
    input wire logic printer_port_select_n,
    input wire logic [2:0] register_select,
    input wire logic [7:0] host_data_bus_in,
    output logic [7:0] host_data_bus_out,
    output logic host_data_bus_oe,
    output logic read_active_out,
    // uart channel status from the serial cores
    input wire hpil_pkg::hpil_irq_src_s chan_a_irq_src,
    input wire hpil_pkg::hpil_irq_src_s chan_b_irq_src,
    input wire logic [1:0] rx_char_avail,
    input wire logic [1:0] rx_trigger_hit,
    input wire logic [1:0] fifo_mode,
    output logic [1:0] chan_irq_out,
    output logic [1:0] chan_irq_oe,
    output logic [1:0] rx_data_avail_n,
    output logic uart_io_enable,
    // printer side
    input wire logic [7:0] printer_data_port_in,
    output logic [7:0] printer_data_port_out,
    output logic printer_data_port_oe,
    input wire logic init_in,
    output logic init_out,
    output logic init_oe,
    input wire hpil_pkg::hpil_prn_in_s prn_in,
    input wire logic irq_latch_select,
    output logic printer_irq_out,
    output logic printer_irq_oe
);
    // synchronised inputs: strobes, selects, printer status
    localparam int SW = 8;
    logic [SW-1:0] raw_vec;
    logic [SW-1:0] syn_vec;
    logic rd_n_s, wr_n_s, csa_n_s, csb_n_s, csp_n_s, ack_n_s, fault_n_s, paper_s;
    logic [7:0] pd_in_s;
    logic init_in_s;

    assign raw_vec = {host_read_strobe_n, host_write_strobe_n, chan_a_select_n,
                      chan_b_select_n, printer_port_select_n, prn_in.ack_n,
                      prn_in.fault_n, prn_in.paper_out};
    assign {rd_n_s, wr_n_s, csa_n_s, csb_n_s, csp_n_s, ack_n_s, fault_n_s, paper_s} = syn_vec;

    // strobes, selects and printer status through two stages before use
    // idle levels: strobes, selects, ack and fault high, paper flag low
    hpil_sync #(.WIDTH(SW), .RST_VAL(8'hfe)) u_sync_ctl (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .async_in(raw_vec),
        .sync_out(syn_vec)
    );

    // printer data and init readback synchronised as a group
    hpil_sync #(.WIDTH(9), .RST_VAL(9'h100)) u_sync_pd (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .async_in({init_in, printer_data_port_in}),
        .sync_out({init_in_s, pd_in_s})
    );

    // strobe edge detection on synchronised levels
    logic rd_n_d_r, wr_n_d_r;
    logic rd_fall, rd_rise, wr_fall;
    assign rd_fall = rd_n_d_r & ~rd_n_s;
    assign rd_rise = ~rd_n_d_r & rd_n_s;
    assign wr_fall = wr_n_d_r & ~wr_n_s;

    // transfer state
    hpil_pkg::hpil_state_e st_r, st_nxt;

    // host visible registers
    logic [7:0] ier_r [2];
    logic [7:0] mcr_r [2];
    logic [7:0] ier_nxt [2];
    logic [7:0] mcr_nxt [2];
    logic [7:0] con_r, con_nxt;
    logic [7:0] pdata_r, pdata_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic rd_oe_r, rd_oe_nxt;
    logic rd_act_r, rd_act_nxt;
    logic [1:0] rd_csel_r, rd_csel_nxt; // {channel b, channel a} select; printer select held in rd_csp_r
    logic rd_csp_r, rd_csp_nxt;

    // printer status byte from bit 7 down: ack, irq pending, paper, fault
    logic pirq_pend_r, pirq_pend_nxt;
    logic [7:0] prn_status;
    assign prn_status = {~ack_n_s, pirq_pend_r, paper_s, fault_n_s, 4'h0};

    // read mux for the register picked at the falling read strobe
    function automatic logic [7:0] read_mux(
        input logic [1:0] csel,
        input logic csp,
        input logic [2:0] sel,
        input logic [7:0] ier0,
        input logic [7:0] ier1,
        input logic [7:0] mcr0,
        input logic [7:0] mcr1,
        input logic [7:0] pdin,
        input logic [7:0] pdat,
        input logic [7:0] stat,
        input logic [7:0] printer_control_reg,
        input logic dir_in
    );
        logic [7:0] v;
        v = hpil_pkg::BUS_IDLE;
        if (csp) begin
            case (sel[1:0])
                hpil_pkg::PRN_DATA_IDX: v = dir_in ? pdin : pdat;
                hpil_pkg::PRN_STAT_IDX: v = stat;
                hpil_pkg::PRN_CTRL_IDX: v = printer_control_reg;
                default: v = hpil_pkg::BUS_IDLE;
            endcase
        end else if (csel != 2'b00) begin
            case (sel)
                hpil_pkg::UART_IER_IDX: v = csel[1] ? ier1 : ier0;
                hpil_pkg::UART_MCR_IDX: v = csel[1] ? mcr1 : mcr0;
                default: v = hpil_pkg::BUS_IDLE;
            endcase
        end
        return v;
    endfunction : read_mux

    // host transfer sequencing and register writes
    always_comb begin
        st_nxt = st_r;
        ier_nxt = ier_r;
        mcr_nxt = mcr_r;
        con_nxt = con_r;
        pdata_nxt = pdata_r;
        rdata_nxt = rdata_r;
        rd_oe_nxt = rd_oe_r;
        rd_act_nxt = rd_act_r;
        rd_csel_nxt = rd_csel_r;
        rd_csp_nxt = rd_csp_r;
        case (st_r)
            hpil_pkg::HPIL_IDLE: begin
                if (rd_fall) begin
                    // capture the selected register onto the bus
                    rd_csel_nxt = {~csb_n_s, ~csa_n_s};
                    rd_csp_nxt = ~csp_n_s;
                    rdata_nxt = read_mux({~csb_n_s, ~csa_n_s}, ~csp_n_s, register_select,
                                         ier_r[0], ier_r[1], mcr_r[0], mcr_r[1], pd_in_s,
                                         pdata_r, prn_status, con_r,
                                         con_r[hpil_pkg::CON_DIR_IN_BIT]);
                    rd_oe_nxt = ~(csa_n_s & csb_n_s & csp_n_s);
                    rd_act_nxt = rd_oe_nxt;
                    st_nxt = hpil_pkg::HPIL_READ;
                end else if (wr_fall) begin
                    // store bus into the addressed register
                    if (!csp_n_s) begin
                        case (register_select[1:0])
                            hpil_pkg::PRN_DATA_IDX: pdata_nxt = host_data_bus_in;
                            hpil_pkg::PRN_CTRL_IDX: con_nxt = host_data_bus_in;
                            default: ;
                        endcase
                    end
                    for (int c = 0; c < 2; c++) begin
                        if ((c == 0 && !csa_n_s) || (c == 1 && !csb_n_s)) begin
                            if (register_select == hpil_pkg::UART_IER_IDX)
                                ier_nxt[c] = host_data_bus_in;
                            if (register_select == hpil_pkg::UART_MCR_IDX)
                                mcr_nxt[c] = host_data_bus_in;
                        end
                    end
                    st_nxt = hpil_pkg::HPIL_WRITE;
                end
            end
            hpil_pkg::HPIL_READ: begin
                if (rd_rise) begin
                    // end of read cycle releases the bus
                    rd_oe_nxt = 1'b0;
                    rd_act_nxt = 1'b0;
                    st_nxt = hpil_pkg::HPIL_IDLE;
                end
            end
            hpil_pkg::HPIL_WRITE: begin
                if (wr_n_s) st_nxt = hpil_pkg::HPIL_IDLE;
            end
            default: st_nxt = hpil_pkg::HPIL_IDLE;
        endcase
    end

    // printer irq: follow or latched mode
    logic pirq_lvl_r, pirq_lvl_nxt;
    logic pirq_oe_r, pirq_oe_nxt;
    logic ack_n_d_r;
    logic ack_fall;
    logic pirq_read_end;
    assign ack_fall = ack_n_d_r & ~ack_n_s;
    assign pirq_read_end = (st_r == hpil_pkg::HPIL_READ) & rd_rise & rd_csp_r;

    always_comb begin
        pirq_pend_nxt = pirq_pend_r;
        // set wins over the clearing read end
        if (ack_fall) pirq_pend_nxt = 1'b1;
        else if (pirq_read_end) pirq_pend_nxt = 1'b0;
        if (!irq_latch_select) begin
            pirq_lvl_nxt = ack_n_s;
        end else begin
            pirq_lvl_nxt = INVERTED_VARIANT ? ~pirq_pend_nxt : pirq_pend_nxt;
        end
        pirq_oe_nxt = con_nxt[hpil_pkg::CON_IRQ_EN_BIT];
    end

    // channel irq pins and rx ready, one per channel
    logic [1:0] cirq_nxt, cirq_oe_nxt, rxrdy_n_nxt;
    hpil_pkg::hpil_irq_src_s src [2];
    assign src[0] = chan_a_irq_src;
    assign src[1] = chan_b_irq_src;

    for (genvar c = 0; c < 2; c++) begin : g_chan
        always_comb begin
            logic cond;
            cond = 1'b0;
            // low nibble of enable register gates the four sources
            cond = (src[c].rx_avail & ier_nxt[c][0]) | (src[c].tx_empty & ier_nxt[c][1])
                 | (src[c].rx_error & ier_nxt[c][2])
                 | (src[c].modem_change & ier_nxt[c][3]);
            cirq_oe_nxt[c] = mcr_nxt[c][hpil_pkg::MCR_IRQ_OE_BIT];
            cirq_nxt[c] = cirq_oe_nxt[c] & cond;
            // fifo mode uses trigger level, otherwise one character
            rxrdy_n_nxt[c] = fifo_mode[c] ? ~rx_trigger_hit[c] : ~rx_char_avail[c];
        end
    end

    // printer port pin drive
    logic pd_oe_nxt, init_oe_nxt;
    always_comb begin
        pd_oe_nxt = ~con_nxt[hpil_pkg::CON_DIR_IN_BIT];
        init_oe_nxt = con_nxt[hpil_pkg::CON_INIT_BIT];
    end

    // all state registers; frozen while clk_en is low
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            // all cleared except strobe/ack delays and rx ready, set high, and state to idle (3'b001); uart pins disabled during reset
            st_r <= hpil_pkg::HPIL_IDLE;
            rd_n_d_r <= 1'b1;
            wr_n_d_r <= 1'b1;
            ack_n_d_r <= 1'b1;
            ier_r[0] <= hpil_pkg::IER_RST;
            ier_r[1] <= hpil_pkg::IER_RST;
            mcr_r[0] <= hpil_pkg::MCR_RST;
            mcr_r[1] <= hpil_pkg::MCR_RST;
            con_r <= hpil_pkg::CON_RST;
            pdata_r <= hpil_pkg::PDATA_RST;
            rdata_r <= hpil_pkg::BUS_IDLE;
            rd_oe_r <= 1'b0;
            rd_act_r <= 1'b0;
            rd_csel_r <= 2'b00;
            rd_csp_r <= 1'b0;
            pirq_pend_r <= 1'b0;
            pirq_lvl_r <= 1'b0;
            pirq_oe_r <= 1'b0;
            chan_irq_out <= 2'b00;
            chan_irq_oe <= 2'b00;
            rx_data_avail_n <= 2'b11;
            printer_data_port_oe <= 1'b0;
            init_oe <= 1'b0;
            uart_io_enable <= 1'b0;
        end else if (clk_en) begin
            st_r <= st_nxt;
            rd_n_d_r <= rd_n_s;
            wr_n_d_r <= wr_n_s;
            ack_n_d_r <= ack_n_s;
            ier_r <= ier_nxt;
            mcr_r <= mcr_nxt;
            con_r <= con_nxt;
            pdata_r <= pdata_nxt;
            rdata_r <= rdata_nxt;
            rd_oe_r <= rd_oe_nxt;
            rd_act_r <= rd_act_nxt;
            rd_csel_r <= rd_csel_nxt;
            rd_csp_r <= rd_csp_nxt;
            pirq_pend_r <= pirq_pend_nxt;
            pirq_lvl_r <= pirq_lvl_nxt;
            pirq_oe_r <= pirq_oe_nxt;
            chan_irq_out <= cirq_nxt;
            chan_irq_oe <= cirq_oe_nxt;
            rx_data_avail_n <= rxrdy_n_nxt;
            printer_data_port_oe <= pd_oe_nxt;
            init_oe <= init_oe_nxt;
            uart_io_enable <= 1'b1;
        end
    end

    // outputs straight from flip-flops; init_out tied low
    assign host_data_bus_out = rdata_r;
    assign host_data_bus_oe = rd_oe_r;
    assign read_active_out = rd_act_r;
    assign printer_data_port_out = pdata_r;
    assign init_out = 1'b0; // open drain: only pulls low when enabled
    assign printer_irq_out = pirq_lvl_r;
    assign printer_irq_oe = pirq_oe_r;
endmodule : hpil_top

// [tb/hpil_top_asserts.sv]
// Purpose: port-level checks for hpil_top
// Assumes: checks pause while reset or clk_en is low
// Notes: bound to every hpil_top at the foot of this file
`timescale 1ns/10ps
module hpil_top_asserts #(
    parameter bit INVERTED_VARIANT = 1'b0 // latched irq release level
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic host_read_strobe_n,
    input wire logic chan_a_select_n,
    input wire logic host_data_bus_oe,
    input wire logic read_active_out,
    input wire hpil_pkg::hpil_irq_src_s chan_a_irq_src,
    input wire logic [1:0] chan_irq_out,
    input wire logic [1:0] chan_irq_oe,
    input wire logic [1:0] rx_char_avail,
    input wire logic [1:0] fifo_mode,
    input wire logic [1:0] rx_data_avail_n,
    input wire logic init_out,
    input wire logic init_oe,
    input wire hpil_pkg::hpil_prn_in_s prn_in,
    input wire logic irq_latch_select,
    input wire logic printer_irq_out,
    input wire logic printer_irq_oe
);
    default clocking @(posedge sys_clk); endclocking
    // frozen cycles hold every output, so attempts spanning them are dropped
    default disable iff (!reset_n || !clk_en);
    a_read_drive: assert property ($fell(host_read_strobe_n) && !chan_a_select_n
        ##1 !host_read_strobe_n [*5] |-> read_active_out) else $error("read not answered");
    a_read_bus_oe: assert property (read_active_out |-> host_data_bus_oe)
        else $error("bus not driven during read");
    a_read_release: assert property ($rose(host_read_strobe_n)
        ##1 host_read_strobe_n [*5] |-> !read_active_out) else $error("read active stuck");
    a_chan_irq_gate: assert property (!chan_irq_oe[0] |-> !chan_irq_out[0])
        else $error("channel irq high while undriven");
    a_chan_irq_src: assert property ((chan_a_irq_src == 4'h0) [*4] |=> !chan_irq_out[0])
        else $error("channel irq without source");
    a_rx_ready_low: assert property ((!fifo_mode[0] && rx_char_avail[0]) [*4]
        |=> !rx_data_avail_n[0]) else $error("rx ready not low");
    a_rx_ready_high: assert property ((!rx_char_avail[0]) [*4] |=> rx_data_avail_n[0])
        else $error("rx ready not high");
    a_follow_ack: assert property ((!irq_latch_select && $stable(prn_in.ack_n)) [*5]
        ##0 printer_irq_oe |-> printer_irq_out == prn_in.ack_n) else $error("irq not following");
    a_latch_hold: assert property ((irq_latch_select && host_read_strobe_n && printer_irq_oe
        && printer_irq_out != INVERTED_VARIANT) [*8] |=> printer_irq_out != INVERTED_VARIANT)
        else $error("latched irq dropped without read");
    a_init_drain: assert property (init_oe |-> !init_out)
        else $error("init driven high");
    a_reset_outs: assert property (!$past(reset_n) |-> !host_data_bus_oe
        && !printer_irq_oe && rx_data_avail_n == 2'h3) else $error("outputs not reset");
    c_read: cover property (read_active_out);
    c_chan_irq: cover property (chan_irq_out[0]);
    c_latched: cover property (irq_latch_select && printer_irq_oe && printer_irq_out);
endmodule : hpil_top_asserts

bind hpil_top hpil_top_asserts #(.INVERTED_VARIANT(INVERTED_VARIANT)) hpil_top_asserts_i (
    .sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
    .host_read_strobe_n(host_read_strobe_n),
    .chan_a_select_n(chan_a_select_n), .host_data_bus_oe(host_data_bus_oe),
    .read_active_out(read_active_out), .chan_a_irq_src(chan_a_irq_src),
    .chan_irq_out(chan_irq_out), .chan_irq_oe(chan_irq_oe), .rx_char_avail(rx_char_avail),
    .fifo_mode(fifo_mode), .rx_data_avail_n(rx_data_avail_n), .init_out(init_out),
    .init_oe(init_oe), .prn_in(prn_in), .irq_latch_select(irq_latch_select),
    .printer_irq_out(printer_irq_out), .printer_irq_oe(printer_irq_oe));

// [tb/hpil_prn_model.sv]
// Purpose: printer on the far side of the printer port
// Assumes: pull-ups on every printer line
// Notes: the bench steers status and acknowledge through the tasks
`timescale 1ns/10ps
module hpil_prn_model (
    input wire logic sys_clk,
    input wire logic [7:0] printer_data_port_out,
    input wire logic printer_data_port_oe,
    input wire logic init_out,
    input wire logic init_oe,
    output logic [7:0] printer_data_port_in,
    output logic init_in,
    output hpil_pkg::hpil_prn_in_s prn_in
);
    // idle: no ack, no fault, paper loaded
    initial prn_in = 3'b110;
    // printer drives its own pattern when the port listens
    assign printer_data_port_in = printer_data_port_oe ? printer_data_port_out : 8'h3c;
    // open drain with pull-up
    assign init_in = !(init_oe && !init_out);
    // status lines change just after an edge
    task automatic set_status(input logic fault_n, input logic paper_out);
        @(posedge sys_clk) #1;
        prn_in.fault_n = fault_n;
        prn_in.paper_out = paper_out;
    endtask : set_status
    // acknowledge level, low per accepted byte
    task automatic set_ack(input logic ack_n);
        @(posedge sys_clk) #1;
        prn_in.ack_n = ack_n;
    endtask : set_ack
endmodule : hpil_prn_model

// [tb/hpil_top_test.sv]
// Purpose: self-checking bench for hpil_top
// Assumes: inputs change 1 ns after the rising edge
// Notes: strobe answer comes 3 edges after the edge, so 6 edges are waited
`timescale 1ns/10ps
module hpil_top_test;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic rd_n = 1'b1, wr_n = 1'b1; // host strobes
    logic [2:0] sel_n = 3'h7; // chan a, chan b, printer selects
    logic [2:0] rsel = 3'h0;
    logic [7:0] wdata = 8'h00, dout, pd_out, pd_in;
    logic dout_oe, rd_act, uart_en, pd_oe, init_in, init_out, init_oe, pirq, pirq_oe;
    hpil_pkg::hpil_irq_src_s src [2] = '{4'h0, 4'h0};
    logic [1:0] char_av = 2'h0, trig = 2'h0, fmode = 2'h0, cirq, cirq_oe, rxr_n;
    logic latch_sel = 1'b0, clk_en = 1'b1;
    hpil_pkg::hpil_prn_in_s prn_in;
    int n_errors = 0, checks_done = 0;
    initial forever #5 sys_clk = ~sys_clk;
    hpil_top hpil_top_i (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
        .host_read_strobe_n(rd_n), .host_write_strobe_n(wr_n), .chan_a_select_n(sel_n[0]),
        .chan_b_select_n(sel_n[1]), .printer_port_select_n(sel_n[2]), .register_select(rsel),
        .host_data_bus_in(wdata), .host_data_bus_out(dout), .host_data_bus_oe(dout_oe),
        .read_active_out(rd_act), .chan_a_irq_src(src[0]), .chan_b_irq_src(src[1]),
        .rx_char_avail(char_av), .rx_trigger_hit(trig), .fifo_mode(fmode),
        .chan_irq_out(cirq), .chan_irq_oe(cirq_oe), .rx_data_avail_n(rxr_n),
        .uart_io_enable(uart_en), .printer_data_port_in(pd_in), .printer_data_port_out(pd_out),
        .printer_data_port_oe(pd_oe), .init_in(init_in), .init_out(init_out),
        .init_oe(init_oe), .prn_in(prn_in), .irq_latch_select(latch_sel),
        .printer_irq_out(pirq), .printer_irq_oe(pirq_oe));
    hpil_prn_model hpil_prn_model_i (.sys_clk(sys_clk), .printer_data_port_out(pd_out),
        .printer_data_port_oe(pd_oe), .init_out(init_out), .init_oe(init_oe),
        .printer_data_port_in(pd_in), .init_in(init_in), .prn_in(prn_in));
    // compare and count
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic settle();
        repeat (4) @(posedge sys_clk);
        #1;
    endtask : settle
    // one host transfer; target 3 selects nothing
    task automatic bus(input bit wr, input int tgt, input logic [2:0] idx,
            input logic [7:0] wd, output logic [7:0] rd);
        @(posedge sys_clk) #1;
        sel_n = ~(3'h1 << tgt);
        rsel = idx;
        wdata = wd;
        if (wr) wr_n = 1'b0; else rd_n = 1'b0;
        repeat (6) @(posedge sys_clk);
        #1;
        rd = dout;
        if (!wr) chk("read active", {7'h0, tgt < 3}, {7'h0, rd_act});
        if (!wr) chk("bus oe", {7'h0, tgt < 3}, {7'h0, dout_oe});
        wr_n = 1'b1;
        rd_n = 1'b1;
        repeat (6) @(posedge sys_clk);
        #1;
        chk("read release", 8'h0, {7'h0, rd_act});
        sel_n = 3'h7;
        wdata = ~wd;
    endtask : bus
    task automatic wr(input int tgt, input logic [2:0] idx, input logic [7:0] d);
        logic [7:0] v;
        bus(1'b1, tgt, idx, d, v);
    endtask : wr
    task automatic rdchk(string nm, input int tgt, input logic [2:0] idx, input logic [7:0] e);
        logic [7:0] v;
        bus(1'b0, tgt, idx, 8'h00, v);
        chk(nm, e, v);
    endtask : rdchk
    // reset clears output enables and sets rx ready high, then uart pins enabled
    task automatic t_reset();
        @(posedge sys_clk) #1;
        reset_n = 1'b0;
        repeat (5) @(posedge sys_clk);
        #1;
        chk("reset oe", 8'h0, {3'h0, dout_oe, pd_oe, pirq_oe, cirq_oe});
        chk("reset rxrdy", 8'h3, {6'h0, rxr_n});
        chk("reset uart en", 8'h0, {7'h0, uart_en});
        reset_n = 1'b1;
        settle();
        chk("uart en", 8'h1, {7'h0, uart_en});
    endtask : t_reset
    // each source against its own enable, gated by modem control bit 3
    task automatic t_chan();
        int sb[4] = '{1, 2, 0, 3};
        for (int ch = 0; ch < 2; ch++) begin
            wr(ch, hpil_pkg::UART_MCR_IDX, 8'h00);
            src[ch] = 4'hf;
            settle();
            chk("irq ungated", 8'h0, {6'h0, cirq_oe[ch], cirq[ch]});
            wr(ch, hpil_pkg::UART_MCR_IDX, 8'h08);
            for (int k = 0; k < 4; k++) begin
                wr(ch, hpil_pkg::UART_IER_IDX, 8'h01 << k);
                src[ch] = 4'h1 << sb[k];
                settle();
                chk("irq on", 8'h3, {6'h0, cirq_oe[ch], cirq[ch]});
                src[ch] = 4'hf & ~(4'h1 << sb[k]);
                settle();
                chk("irq off", 8'h0, {7'h0, cirq[ch]});
            end
            rdchk("ier", ch, hpil_pkg::UART_IER_IDX, 8'h08);
            rdchk("unmapped", ch, 3'h7, 8'h00);
            src[ch] = 4'h0;
        end
    endtask : t_chan
    // rx ready in character and trigger modes
    task automatic t_rx();
        for (int ch = 0; ch < 2; ch++) begin
            // frozen clock enable must hold the pin, then release it
            clk_en = 1'b0;
            char_av[ch] = 1'b1;
            settle();
            chk("rxrdy frozen", 8'h1, {7'h0, rxr_n[ch]});
            clk_en = 1'b1;
            settle();
            chk("rxrdy char", 8'h0, {7'h0, rxr_n[ch]});
            fmode[ch] = 1'b1;
            settle();
            chk("rxrdy below trig", 8'h1, {7'h0, rxr_n[ch]});
            trig[ch] = 1'b1;
            settle();
            chk("rxrdy trig", 8'h0, {7'h0, rxr_n[ch]});
            {char_av[ch], trig[ch], fmode[ch]} = 3'h0;
            settle();
            chk("rxrdy empty", 8'h1, {7'h0, rxr_n[ch]});
        end
    endtask : t_rx
    // printer data, direction, init, status
    task automatic t_prn();
        wr(2, hpil_pkg::PRN_DATA_IDX, 8'ha5);
        chk("pdata", 8'ha5, pd_out);
        chk("pdata oe", 8'h1, {7'h0, pd_oe});
        rdchk("pdata read", 2, hpil_pkg::PRN_DATA_IDX, 8'ha5);
        rdchk("prn unmapped", 2, 3'h3, 8'h00);
        rdchk("no select", 3, 3'h0, 8'h00);
        wr(2, hpil_pkg::PRN_CTRL_IDX, 8'h24);
        chk("pdata input", 8'h0, {7'h0, pd_oe});
        rdchk("pdata pins", 2, hpil_pkg::PRN_DATA_IDX, 8'h3c);
        chk("init low", 8'h0, {7'h0, init_in});
        wr(2, hpil_pkg::PRN_CTRL_IDX, 8'h00);
        chk("init release", 8'h1, {7'h0, init_in});
        hpil_prn_model_i.set_status(1'b0, 1'b1);
        rdchk("status err", 2, hpil_pkg::PRN_STAT_IDX, 8'h20);
        hpil_prn_model_i.set_status(1'b1, 1'b0);
        rdchk("status ok", 2, hpil_pkg::PRN_STAT_IDX, 8'h10);
    endtask : t_prn
    // printer irq: tristate, follow, latched until read ends
    task automatic t_pirq();
        hpil_prn_model_i.set_ack(1'b0);
        settle();
        chk("pirq hiz", 8'h0, {7'h0, pirq_oe});
        hpil_prn_model_i.set_ack(1'b1);
        wr(2, hpil_pkg::PRN_CTRL_IDX, 8'h10);
        chk("pirq idle", 8'h3, {6'h0, pirq_oe, pirq});
        hpil_prn_model_i.set_ack(1'b0);
        settle();
        chk("pirq follow", 8'h0, {7'h0, pirq});
        hpil_prn_model_i.set_ack(1'b1);
        settle();
        latch_sel = 1'b1;
        hpil_prn_model_i.set_ack(1'b0);
        settle();
        hpil_prn_model_i.set_ack(1'b1);
        repeat (3) settle();
        chk("pirq held", 8'h1, {7'h0, pirq});
        rdchk("status pend", 2, hpil_pkg::PRN_STAT_IDX, 8'h50);
        chk("pirq cleared", 8'h0, {7'h0, pirq});
        latch_sel = 1'b0;
    endtask : t_pirq
    task automatic finish_test();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : finish_test
    initial begin
        repeat (30000) @(posedge sys_clk);
        n_errors++;
        finish_test();
    end
    initial begin
        t_reset();
        t_chan();
        t_rx();
        t_prn();
        t_pirq();
        t_reset();
        finish_test();
    end
endmodule : hpil_top_test
